// >>> include/lrtc_defines.svh
// constants of the logger rtc and configuration block
`ifndef LRTC_DEFINES_SVH
`define LRTC_DEFINES_SVH

// register indices; byte address is four times the index
`define LRTC_IDX_SEC      10'h200
`define LRTC_IDX_MIN      10'h201
`define LRTC_IDX_HOUR     10'h202
`define LRTC_IDX_WDAY     10'h203
`define LRTC_IDX_DATE     10'h204
`define LRTC_IDX_MONTH    10'h205
`define LRTC_IDX_YEAR     10'h206
`define LRTC_IDX_ASEC     10'h207
`define LRTC_IDX_AMIN     10'h208
`define LRTC_IDX_AHOUR    10'h209
`define LRTC_IDX_AWDAY    10'h20A
`define LRTC_IDX_TLOW     10'h20B
`define LRTC_IDX_THIGH    10'h20C
`define LRTC_IDX_RATE     10'h20D
`define LRTC_IDX_CTRL     10'h20E
`define LRTC_IDX_TEMP     10'h211
`define LRTC_IDX_STATUS   10'h214

// writable bits; fixed-zero bits are dropped on write
`define LRTC_WM_SEC       8'h7F
`define LRTC_WM_HOUR      8'h7F
`define LRTC_WM_WDAY      8'h07
`define LRTC_WM_DATE      8'h3F
`define LRTC_WM_MONTH     8'h9F
`define LRTC_WM_AWDAY     8'h87
`define LRTC_WM_CTRL      8'hDF

// field positions
`define LRTC_B_MASK       7
`define LRTC_B_MODE12     6
`define LRTC_B_PM         5
`define LRTC_B_HUNDRED_YEAR_FLAG       7
`define LRTC_B_OSCOFF     7
`define LRTC_B_MENA_N     4
`define LRTC_B_LOGWRAP    3
`define LRTC_B_TLS        2
`define LRTC_B_THS        1
`define LRTC_B_TAS        0
`define LRTC_B_MEMORY_CLEARED     6
`define LRTC_B_MIP        5
`define LRTC_B_TLF        2
`define LRTC_B_THF        1
`define LRTC_B_TAF        0

// calendar figures in bcd
`define LRTC_BCD_59       7'h59
`define LRTC_BCD_ONE      8'h01
`define LRTC_BCD_11       5'h11
`define LRTC_BCD_12       5'h12
`define LRTC_BCD_23       6'h23
`define LRTC_BCD_99       8'h99
`define LRTC_BCD_FEB      5'h02
`define LRTC_DAYS_7       3'h7
`define LRTC_RST_TIME     8'h00
`define LRTC_RST_DAY      8'h01

// one second tick
`define LRTC_CLK_HZ       125000000
`define LRTC_TICK_S       1

// temperature code limits
`define LRTC_CODE_MIN     8'h00
`define LRTC_CODE_MAX     8'hFF

`endif

// >>> include/lrtc_pkg.sv
// types of the logger rtc and configuration block
package lrtc_pkg;

  typedef enum logic {
    LRTC_IDLE,
    LRTC_MISSION
  } lrtc_mission_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
    logic [5:0] bin;
  } lrtc_temp_t;

endpackage : lrtc_pkg

// >>> design/lrtc_temp_code.sv
// clamps a raw conversion into the one-byte code and its histogram bin
`timescale 1ns/10ps
`default_nettype none
`include "lrtc_defines.svh"

module lrtc_temp_code
(
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_valid,
  input  wire logic signed [11:0]  i_raw,
  output lrtc_pkg::lrtc_temp_t     o_temp
);

  logic [7:0] next_code;

  always_comb
  begin
    if (i_raw < 12'sh000)
      next_code = `LRTC_CODE_MIN;
    else if (i_raw > 12'sh0FF)
      next_code = `LRTC_CODE_MAX;
    else
      next_code = i_raw[7:0];
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_temp <= '0;
    else
    begin
      o_temp.valid <= i_valid;
      if (i_valid)
      begin
        o_temp.code <= next_code;
        // four codes per bin: 00h lands in 0, FFh in 63, 04h..FBh in 1..62
        o_temp.bin  <= next_code[7:2];
      end
    end
  end

endmodule : lrtc_temp_code
`default_nettype wire

// >>> design/lrtc_core.sv
// logger rtc, alarm and configuration registers behind a wishbone slave
// Contract
// - hours bit 6 selects 12-hour mode when 1, 24-hour when 0
// - hours bit 5 is pm in 12-hour mode, twenty-hours digit in 24-hour
// - weekday_count counts 1 to 7, meaning chosen by user
// - february 29 inserted when year is 00 or multiple of 4
// - months bit 7 century flag toggles when year rolls 99 to 00
// - alarm register bit 7 masks its field out of the comparison
// - all four masks set gives an alarm every second
// - clearing masks adds seconds, then minutes, then hours to the match
// - all masks clear gives weekly alarm on seconds, minutes, hours, weekday
// - every clock alarm sets the timer alarm flag in status
// - search bits let the device answer conditional search on an alarm
// - temperature is one unsigned byte in eighth-degree steps, 01h..FEh valid
// - below range stores 00h, above range stores FFh
// - out-of-range codes fall in bins 0 and 63, 04h..FBh in 1..62
// - logged and forced readout codes share one encoding
// - low threshold byte at 20Bh, high threshold byte at 20Ch
// - sample interval is 1 to 255 minutes between conversions
// - nonzero interval write starts mission if memory cleared and enable low
// - control write during a mission ends it and updates the register
// - control bit 5 always reads 0 and ignores writes
// - time, calendar and alarm registers hold bcd
// - fixed-zero bits always read 0 whatever is written
// - protected registers stay readable; first write ends the mission
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "lrtc_defines.svh"

module lrtc_core
#(
  parameter int TICK_CYCLES = `LRTC_CLK_HZ * `LRTC_TICK_S
)
(
  input  wire logic                i_mclk,
  input  wire logic                i_rst,
  input  wire logic                i_wb_cyc,
  input  wire logic                i_wb_stb,
  input  wire logic                i_wb_we,
  input  wire logic [11:0]         i_wb_adr,
  input  wire logic [3:0]          i_wb_sel,
  input  wire logic [31:0]         i_wb_dat,
  output logic [31:0]              o_wb_dat,
  output logic                     o_wb_ack,
  input  wire logic                i_memory_cleared,
  input  wire logic                i_temp_valid,
  input  wire logic signed [11:0]  i_temp_raw,
  output lrtc_pkg::lrtc_temp_t     o_temp,
  output logic                     o_mission_active,
  output logic                     o_search_hit,
  output logic [7:0]               o_sample_interval,
  output logic                     o_log_wrap
);

  // registers
  logic [7:0]             seconds_count;
  logic [7:0]             minutes_count;
  logic [7:0]             hours_count;
  logic [7:0]             weekday_count;
  logic [7:0]             date_count;
  logic [7:0]             month_century;
  logic [7:0]             year_count;
  logic [7:0]             seconds_alarm;
  logic [7:0]             minutes_alarm;
  logic [7:0]             hours_alarm;
  logic [7:0]             weekday_alarm;
  logic [7:0]             temp_low_threshold;
  logic [7:0]             temp_high_threshold;
  logic [7:0]             sample_interval;
  logic [7:0]             device_control;
  logic [7:0]             temp_readout;
  logic                   timer_alarm_flag;
  logic                   low_temp_flag;
  logic                   high_temp_flag;
  lrtc_pkg::lrtc_mission_t mission;

  logic [26:0]            tick_cnt;
  logic                   tick;
  logic                   alarm_check;
  logic                   alarm_hit;
  logic                   wr;
  logic [9:0]             idx;
  logic [7:0]             wd;
  logic [7:0]             rd;
  logic                   protected_wr;
  logic                   mission_start;
  logic                   sec_wrap;
  logic                   min_wrap;
  logic                   day_wrap;
  logic                   month_wrap;
  logic                   year_wrap;
  logic [7:0]             next_hours;
  logic [7:0]             month_days;

  // bcd increment of one byte: ones at 9 carry into tens
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction : bcd_inc

  // bcd year divisible by four: even tens with 0/4/8, odd tens with 2/6
  function automatic logic leap(input logic [7:0] y);
    if (y[4])
      leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction : leap

  // ---------------------------------------------------------------
  // bus slave: one wait state, ack drops the cycle after it is given
  // ---------------------------------------------------------------
  assign idx = i_wb_adr[11:2];
  assign wd  = i_wb_dat[7:0];
  assign wr  = i_wb_cyc & i_wb_stb & i_wb_we & i_wb_sel[0] & ~o_wb_ack;

  always_comb
  begin
    case (idx)
      `LRTC_IDX_SEC:    rd = seconds_count;
      `LRTC_IDX_MIN:    rd = minutes_count;
      `LRTC_IDX_HOUR:   rd = hours_count;
      `LRTC_IDX_WDAY:   rd = weekday_count;
      `LRTC_IDX_DATE:   rd = date_count;
      `LRTC_IDX_MONTH:  rd = month_century;
      `LRTC_IDX_YEAR:   rd = year_count;
      `LRTC_IDX_ASEC:   rd = seconds_alarm;
      `LRTC_IDX_AMIN:   rd = minutes_alarm;
      `LRTC_IDX_AHOUR:  rd = hours_alarm;
      `LRTC_IDX_AWDAY:  rd = weekday_alarm;
      `LRTC_IDX_TLOW:   rd = temp_low_threshold;
      `LRTC_IDX_THIGH:  rd = temp_high_threshold;
      `LRTC_IDX_RATE:   rd = sample_interval;
      `LRTC_IDX_CTRL:   rd = device_control;
      `LRTC_IDX_TEMP:   rd = temp_readout;
      `LRTC_IDX_STATUS:
      begin
        rd = '0;
        rd[`LRTC_B_MEMORY_CLEARED] = i_memory_cleared;
        rd[`LRTC_B_MIP]    = (mission == lrtc_pkg::LRTC_MISSION);
        rd[`LRTC_B_TLF]    = low_temp_flag;
        rd[`LRTC_B_THF]    = high_temp_flag;
        rd[`LRTC_B_TAF]    = timer_alarm_flag;
      end
      default:          rd = '0;
    endcase
  end

  // reads stay open during a mission; unmapped reads return zero
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end
    else
    begin
      o_wb_ack <= i_wb_cyc & i_wb_stb & ~o_wb_ack;
      if (i_wb_cyc & i_wb_stb & ~o_wb_ack & ~i_wb_we)
        o_wb_dat <= {24'h000000, rd};
    end
  end

  // ---------------------------------------------------------------
  // one second tick; held off while the oscillator is disabled
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tick_cnt <= '0;
      tick     <= 1'b0;
    end
    else if (device_control[`LRTC_B_OSCOFF])
      tick <= 1'b0;
    else if (tick_cnt == 27'(TICK_CYCLES - 1))
    begin
      tick_cnt <= '0;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 27'h1;
      tick     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // timekeeping carries
  // ---------------------------------------------------------------
  assign sec_wrap   = tick & (seconds_count[6:0] == `LRTC_BCD_59);
  assign min_wrap   = sec_wrap & (minutes_count[6:0] == `LRTC_BCD_59);
  assign month_wrap = day_wrap & (date_count == month_days);
  assign year_wrap  = month_wrap & (month_century[4:0] == `LRTC_BCD_12);

  always_comb
  begin
    case (month_century[4:0])
      `LRTC_BCD_FEB:
        month_days = leap(year_count) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, `LRTC_BCD_11:
        month_days = 8'h30;
      default:
        month_days = 8'h31;
    endcase
  end

  always_comb
  begin
    next_hours = hours_count;
    day_wrap   = 1'b0;
    if (hours_count[`LRTC_B_MODE12])
    begin
      // 12-hour: 11 -> 12 flips pm, 12 -> 01; pm 11 -> am 12 ends the day
      if (hours_count[4:0] == `LRTC_BCD_12)
        next_hours[4:0] = 5'(`LRTC_BCD_ONE);
      else if (hours_count[4:0] == `LRTC_BCD_11)
      begin
        next_hours[4:0] = `LRTC_BCD_12;
        next_hours[`LRTC_B_PM] = ~hours_count[`LRTC_B_PM];
        day_wrap = min_wrap & hours_count[`LRTC_B_PM];
      end
      else
        // format and pm bits sit above the tens digit and never take a carry
        next_hours = bcd_inc(hours_count);
    end
    else if (hours_count[5:0] == `LRTC_BCD_23)
    begin
      next_hours[5:0] = 6'h00;
      day_wrap = min_wrap;
    end
    else
      next_hours = bcd_inc(hours_count);
  end

  // a bus write to a field wins over the tick in that same cycle
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      seconds_count <= `LRTC_RST_TIME;
      minutes_count <= `LRTC_RST_TIME;
      hours_count   <= `LRTC_RST_TIME;
      weekday_count <= `LRTC_RST_DAY;
      date_count    <= `LRTC_RST_DAY;
      month_century <= `LRTC_RST_DAY;
      year_count    <= `LRTC_RST_TIME;
    end
    else
    begin
      if (wr && idx == `LRTC_IDX_SEC)
        seconds_count <= wd & `LRTC_WM_SEC;
      else if (sec_wrap)
        seconds_count <= `LRTC_RST_TIME;
      else if (tick)
        seconds_count <= bcd_inc(seconds_count);

      if (wr && idx == `LRTC_IDX_MIN)
        minutes_count <= wd & `LRTC_WM_SEC;
      else if (min_wrap)
        minutes_count <= `LRTC_RST_TIME;
      else if (sec_wrap)
        minutes_count <= bcd_inc(minutes_count);

      if (wr && idx == `LRTC_IDX_HOUR)
        hours_count <= wd & `LRTC_WM_HOUR;
      else if (min_wrap)
        hours_count <= next_hours;

      if (wr && idx == `LRTC_IDX_WDAY)
        weekday_count <= wd & `LRTC_WM_WDAY;
      else if (day_wrap)
        weekday_count <= (weekday_count[2:0] >= `LRTC_DAYS_7) ?
                         `LRTC_RST_DAY : weekday_count + 8'h01;

      if (wr && idx == `LRTC_IDX_DATE)
        date_count <= wd & `LRTC_WM_DATE;
      else if (month_wrap)
        date_count <= `LRTC_BCD_ONE;
      else if (day_wrap)
        date_count <= bcd_inc(date_count);

      if (wr && idx == `LRTC_IDX_MONTH)
        month_century <= wd & `LRTC_WM_MONTH;
      else if (year_wrap)
      begin
        month_century[4:0] <= 5'(`LRTC_BCD_ONE);
        if (year_count == `LRTC_BCD_99)
          month_century[`LRTC_B_HUNDRED_YEAR_FLAG] <= ~month_century[`LRTC_B_HUNDRED_YEAR_FLAG];
      end
      else if (month_wrap)
        month_century <= bcd_inc(month_century);

      if (wr && idx == `LRTC_IDX_YEAR)
        year_count <= wd;
      else if (year_wrap)
        year_count <= (year_count == `LRTC_BCD_99) ?
                      `LRTC_RST_TIME : bcd_inc(year_count);
    end
  end

  // ---------------------------------------------------------------
  // alarm registers and comparison, one cycle after the tick
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      seconds_alarm <= `LRTC_RST_TIME;
      minutes_alarm <= `LRTC_RST_TIME;
      hours_alarm   <= `LRTC_RST_TIME;
      weekday_alarm <= `LRTC_RST_TIME;
      alarm_check   <= 1'b0;
    end
    else
    begin
      alarm_check <= tick;
      if (wr && idx == `LRTC_IDX_ASEC)
        seconds_alarm <= wd;
      if (wr && idx == `LRTC_IDX_AMIN)
        minutes_alarm <= wd;
      if (wr && idx == `LRTC_IDX_AHOUR)
        hours_alarm <= wd;
      if (wr && idx == `LRTC_IDX_AWDAY)
        weekday_alarm <= wd & `LRTC_WM_AWDAY;
    end
  end

  // a set mask removes its field; all four set fires every second
  assign alarm_hit = alarm_check
    & (seconds_alarm[`LRTC_B_MASK] | seconds_alarm[6:0] == seconds_count[6:0])
    & (minutes_alarm[`LRTC_B_MASK] | minutes_alarm[6:0] == minutes_count[6:0])
    & (hours_alarm[`LRTC_B_MASK]   | hours_alarm[6:0] == hours_count[6:0])
    & (weekday_alarm[`LRTC_B_MASK] | weekday_alarm[2:0] == weekday_count[2:0]);

  // ---------------------------------------------------------------
  // configuration registers and mission control
  // ---------------------------------------------------------------
  assign protected_wr  = wr && idx >= `LRTC_IDX_SEC && idx < `LRTC_IDX_STATUS;
  assign mission_start = wr && idx == `LRTC_IDX_RATE && wd != 8'h00 &&
                         i_memory_cleared && !device_control[`LRTC_B_MENA_N];

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      temp_low_threshold  <= `LRTC_RST_TIME;
      temp_high_threshold <= `LRTC_RST_TIME;
      sample_interval     <= `LRTC_RST_TIME;
      device_control      <= `LRTC_RST_TIME;
    end
    else
    begin
      if (wr && idx == `LRTC_IDX_TLOW)
        temp_low_threshold <= wd;
      if (wr && idx == `LRTC_IDX_THIGH)
        temp_high_threshold <= wd;
      // interval is read-only while a mission runs; the write only ends it
      if (wr && idx == `LRTC_IDX_RATE && mission == lrtc_pkg::LRTC_IDLE)
        sample_interval <= wd;
      if (wr && idx == `LRTC_IDX_CTRL)
        device_control <= wd & `LRTC_WM_CTRL;
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      mission <= lrtc_pkg::LRTC_IDLE;
    else
    begin
      case (mission)
        lrtc_pkg::LRTC_IDLE:
          if (mission_start)
            mission <= lrtc_pkg::LRTC_MISSION;
        lrtc_pkg::LRTC_MISSION:
          if (protected_wr)
            mission <= lrtc_pkg::LRTC_IDLE;
        default:
          mission <= lrtc_pkg::LRTC_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // status flags: hardware set wins over a software clear
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      timer_alarm_flag <= 1'b0;
      low_temp_flag    <= 1'b0;
      high_temp_flag   <= 1'b0;
      temp_readout     <= `LRTC_CODE_MIN;
    end
    else
    begin
      if (alarm_hit)
        timer_alarm_flag <= 1'b1;
      else if (wr && idx == `LRTC_IDX_STATUS && !wd[`LRTC_B_TAF])
        timer_alarm_flag <= 1'b0;

      if (o_temp.valid && mission == lrtc_pkg::LRTC_MISSION &&
          o_temp.code <= temp_low_threshold)
        low_temp_flag <= 1'b1;
      else if (wr && idx == `LRTC_IDX_STATUS && !wd[`LRTC_B_TLF])
        low_temp_flag <= 1'b0;

      if (o_temp.valid && mission == lrtc_pkg::LRTC_MISSION &&
          o_temp.code >= temp_high_threshold)
        high_temp_flag <= 1'b1;
      else if (wr && idx == `LRTC_IDX_STATUS && !wd[`LRTC_B_THF])
        high_temp_flag <= 1'b0;

      if (o_temp.valid)
        temp_readout <= o_temp.code;
    end
  end

  lrtc_temp_code u_temp
  (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (i_temp_valid),
    .i_raw   (i_temp_raw),
    .o_temp  (o_temp)
  );

  assign o_mission_active  = (mission == lrtc_pkg::LRTC_MISSION);
  assign o_sample_interval = sample_interval;
  assign o_log_wrap        = device_control[`LRTC_B_LOGWRAP];
  assign o_search_hit = (device_control[`LRTC_B_TAS] & timer_alarm_flag)
                      | (device_control[`LRTC_B_TLS] & low_temp_flag)
                      | (device_control[`LRTC_B_THS] & high_temp_flag);

endmodule : lrtc_core
`default_nettype wire

// >>> bench/lrtc_wb_host.sv
// wishbone master standing in for the register page host
`timescale 1ns/10ps
`default_nettype none
module lrtc_wb_host
(
  input  wire logic        i_mclk,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_rdat,
  output logic             o_cyc,
  output logic             o_we,
  output logic [11:0]      o_adr,
  output logic [31:0]      o_dat
);
  initial
  begin
    o_cyc = 1'b0;
    o_we  = 1'b0;
    o_adr = 12'h000;
    o_dat = 32'h0;
  end
  // released lines are inverted so a late sample by the slave shows up
  task automatic xfer(input logic we, input logic [9:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge i_mclk);
    o_cyc <= 1'b1;
    o_we  <= we;
    o_adr <= {idx, 2'b00};
    o_dat <= {24'h0, wd};
    @(posedge i_mclk);
    while (i_ack !== 1'b1)
      @(posedge i_mclk);
    rd = i_rdat[7:0];
    o_cyc <= 1'b0;
    o_adr <= ~{idx, 2'b00};
    o_dat <= ~{24'h0, wd};
  endtask : xfer
endmodule : lrtc_wb_host
`default_nettype wire

// >>> bench/lrtc_core_props.sv
// concurrent checks on the logger rtc block ports
`timescale 1ns/10ps
`default_nettype none
module lrtc_core_props
(
  input wire logic                 i_mclk,
  input wire logic                 i_rst,
  input wire logic                 i_wb_cyc,
  input wire logic                 i_wb_stb,
  input wire logic                 i_wb_we,
  input wire logic [11:0]          i_wb_adr,
  input wire logic [3:0]           i_wb_sel,
  input wire logic [31:0]          i_wb_dat,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_wb_ack,
  input wire logic                 i_temp_valid,
  input wire logic signed [11:0]   i_temp_raw,
  input wire lrtc_pkg::lrtc_temp_t o_temp,
  input wire logic                 o_mission_active,
  input wire logic [7:0]           o_sample_interval,
  input wire logic                 o_log_wrap
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // ack low marks a fresh request, since the slave answers one cycle later
  wire       tk    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire       wtk   = tk & i_wb_we & i_wb_sel[0];
  wire       rdk   = o_wb_ack & ~i_wb_we;
  wire [9:0] ix    = i_wb_adr[11:2];
  wire [7:0] wb    = i_wb_dat[7:0];
  wire       wb3   = i_wb_dat[3];
  wire [7:0] clamp = (i_temp_raw < 0) ? 8'h00 : (i_temp_raw > 255) ? 8'hFF : i_temp_raw[7:0];
  a_ack_pulse: assert property (tk |=> o_wb_ack ##1 !o_wb_ack)
    else $error("ack is not one pulse per request");
  a_temp_clamp: assert property (i_temp_valid |=> o_temp.valid && o_temp.code == $past(clamp))
    else $error("temperature code not clamped");
  a_temp_bin: assert property (o_temp.valid |-> o_temp.bin == o_temp.code[7:2])
    else $error("histogram bin wrong");
  a_ival_store: assert property (wtk && ix == 10'h20D && !o_mission_active
    |=> o_sample_interval == $past(wb))
    else $error("interval not stored");
  a_ival_hold: assert property (wtk && ix == 10'h20D && o_mission_active
    |=> $stable(o_sample_interval) && !o_mission_active)
    else $error("interval write in mission misbehaves");
  a_ctrl_end: assert property (wtk && ix == 10'h20E
    |=> !o_mission_active && o_log_wrap == $past(wb3))
    else $error("control write did not end mission or update");
  a_ctrl_b5: assert property (rdk && ix == 10'h20E |-> !o_wb_dat[5])
    else $error("control bit 5 reads one");
  a_wday_zero: assert property (rdk && ix == 10'h203 |-> o_wb_dat[7:3] == 5'h00)
    else $error("weekday high bits not zero");
  a_time_b7: assert property (rdk && ix inside {10'h200, 10'h201, 10'h202, 10'h204}
    |-> !o_wb_dat[7])
    else $error("time bit 7 not zero");
endmodule : lrtc_core_props
`default_nettype wire

// >>> bench/lrtc_core_test.sv
// self-checking bench of the logger rtc register block
`timescale 1ns/10ps
`default_nettype none
module lrtc_core_test;
  logic                 clk;
  logic                 rst;
  logic                 mcl;
  logic                 tv;
  logic signed [11:0]   raw;
  logic                 cyc;
  logic                 we;
  logic                 ack;
  logic                 hit;
  logic                 mact;
  logic                 lwrap;
  logic [11:0]          adr;
  logic [31:0]          wd;
  logic [31:0]          rdat;
  logic [7:0]           ival;
  logic [7:0]           v;
  lrtc_pkg::lrtc_temp_t tmp;
  int                   miscompares;
  int                   checks;
  int                   ncyc;
  // sec min hour wday date month year, before and after one tick
  logic [55:0] tin [6] = '{56'h59592307280203, 56'h59592303280204, 56'h59592301280200,
                           56'h59597102311299, 56'h59595105158124, 56'h59591906300424};
  logic [55:0] tout [6] = '{56'h00000001010303, 56'h00000004290204, 56'h00000002290200,
                            56'h00005203018100, 56'h00007205158124, 56'h00002006300424};
  // alarm bytes, then whether status shows the alarm
  logic [35:0] al [8] = '{36'h808080801, 36'h058080801, 36'h068080800, 36'h050180800,
                          36'h050000801, 36'h050001800, 36'h050000031, 36'h050000040};
  logic [7:0]  wm [16] = '{8'h7F, 8'h7F, 8'h7F, 8'h07, 8'h3F, 8'h9F, 8'hFF, 8'hFF,
                           8'hFF, 8'hFF, 8'h87, 8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'h00};
  // raw conversion, then stored code
  logic [19:0] tt [8] = '{20'hFFB00, 20'h00000, 20'h00101, 20'h06464,
                          20'h0FBFB, 20'h0FEFE, 20'h0FFFF, 20'h100FF};
  lrtc_wb_host host (.i_mclk(clk), .i_ack(ack), .i_rdat(rdat), .o_cyc(cyc), .o_we(we),
                     .o_adr(adr), .o_dat(wd));
  lrtc_core #(.TICK_CYCLES(40)) uut
  (
    .i_mclk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(cyc), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_memory_cleared(mcl), .i_temp_valid(tv), .i_temp_raw(raw), .o_temp(tmp),
    .o_mission_active(mact), .o_search_hit(hit), .o_sample_interval(ival),
    .o_log_wrap(lwrap)
  );
  task automatic wrap_up;
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b1, i, d, x);
  endtask : wr
  task automatic rdc(input logic [9:0] i, input logic [7:0] e);
    host.xfer(1'b0, i, 8'h00, v);
    chk(v, e);
  endtask : rdc
  // polls the seconds count; the global timeout ends a hang
  task automatic wait_sec(input logic [7:0] s);
    v = 8'hEE;
    while (v !== s)
      host.xfer(1'b0, 10'h200, 8'h00, v);
  endtask : wait_sec
  task automatic temp_case(input logic [19:0] t);
    @(posedge clk);
    tv <= 1'b1;
    raw <= t[19:8];
    @(posedge clk);
    tv <= 1'b0;
    rdc(10'h211, t[7:0]);
    chk(tmp.code, t[7:0]);
    chk({2'b0, tmp.bin}, {2'b0, t[7:2]});
  endtask : temp_case
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    ncyc++;
    if (ncyc == 20000)
    begin
      miscompares++;
      wrap_up();
    end
  end
  initial
  begin
    rst = 1'b1;
    mcl = 1'b0;
    tv  = 1'b0;
    raw = 12'h000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // stop the oscillator before the first tick so reset values stay put
    wr(10'h20E, 8'hA0);
    rdc(10'h20E, 8'h80);
    for (int k = 0; k < 14; k++)
      rdc(10'h200 + 10'(k), (k > 2 && k < 6) ? 8'h01 : 8'h00);
    for (int k = 0; k < 16; k++)
      wr(10'h200 + 10'(k), 8'hFF);
    for (int k = 0; k < 16; k++)
      rdc(10'h200 + 10'(k), wm[k]);
    for (int k = 0; k < 6; k++)
    begin
      wr(10'h20E, 8'h80);
      for (int j = 0; j < 7; j++)
        wr(10'h200 + 10'(j), tin[k][55 - 8 * j -: 8]);
      wr(10'h20E, 8'h00);
      wait_sec(8'h00);
      wr(10'h20E, 8'h80);
      for (int j = 0; j < 7; j++)
        rdc(10'h200 + 10'(j), tout[k][55 - 8 * j -: 8]);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(10'h20E, 8'h80);
      for (int j = 0; j < 4; j++)
      begin
        wr(10'h200 + 10'(j), (j % 3 == 0) ? 8'h03 : 8'h00);
        wr(10'h207 + 10'(j), al[k][35 - 8 * j -: 8]);
      end
      wr(10'h20E, 8'h01);
      wait_sec(8'h04);
      wr(10'h214, 8'h00);
      wait_sec(8'h05);
      rdc(10'h214, {7'h0, al[k][0]});
      chk({7'h0, hit}, {7'h0, al[k][0]});
    end
    for (int k = 0; k < 8; k++)
      temp_case(tt[k]);
    wr(10'h20E, 8'h00);
    wr(10'h20B, 8'h40);
    wr(10'h20C, 8'hC0);
    mcl <= 1'b1;
    wr(10'h20D, 8'h00);
    chk({7'h0, mact}, 8'h00);
    wr(10'h20D, 8'h0A);
    chk({7'h0, mact}, 8'h01);
    chk(ival, 8'h0A);
    temp_case(20'h03030);
    temp_case(20'h0D0D0);
    host.xfer(1'b0, 10'h214, 8'h00, v);
    chk(v & 8'h66, 8'h66);
    wr(10'h20D, 8'h05);
    chk({6'h0, mact, ival == 8'h0A}, 8'h01);
    wr(10'h20D, 8'h0A);
    wr(10'h20E, 8'h0E);
    chk({6'h0, mact, lwrap}, 8'h01);
    chk({7'h0, hit}, 8'h01);
    rdc(10'h20E, 8'h0E);
    wr(10'h20E, 8'h10);
    wr(10'h20D, 8'h03);
    chk({7'h0, mact}, 8'h00);
    wrap_up();
  end
endmodule : lrtc_core_test
bind lrtc_core lrtc_core_props props_i
(
  .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_temp_valid(i_temp_valid),
  .i_temp_raw(i_temp_raw), .o_temp(o_temp), .o_mission_active(o_mission_active),
  .o_sample_interval(o_sample_interval), .o_log_wrap(o_log_wrap)
);
`default_nettype wire
